// [core/standby_defs.svh]
// Purpose: Timing counts, field width and reset values of the standby controller
// Assumes: Included by bare name
// Notes:   Stabilization status is five bits, msb first
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH
`define STAB_BITS        5
`define STAB_STATUS_RST  5'h00
`define STAB_SEL_RST     3'h5
`define INT_HOLD_PERIODS 17
`define OSC_START_CYCLES 8
`define STAB_BASE_EXP    4
`endif

// [core/standby_pkg.sv]
// Purpose: Types of the standby controller
// Assumes: Nothing
// Notes:   Clock source codes are local choices
package standby_pkg;
  typedef enum logic [1:0] {
    CLK_HIGH_SPEED,
    CLK_INT_OSC,
    CLK_SUBSYSTEM
  } cpu_clk_src_t;
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_STOP,
    MODE_OSC_START,
    MODE_STAB_WAIT,
    MODE_INT_HOLD
  } standby_mode_t;
  typedef struct packed {
    logic haltReq;
    logic stopReq;
    logic wakeReq;
  } cpu_cmd_t;
  typedef struct packed {
    logic highSpeedOscEn;
    logic intOscEn;
    logic cpuHold;
    logic inHalt;
    logic inStop;
    logic stopRefused;
  } standby_out_t;
endpackage

// [core/stab_counter.sv]
// Purpose: Oscillation stabilization counter with sticky status bits
// Assumes: Start pulse at release of the oscillator start interval
// Notes:   Status bit BITS-1-k set after 2^(base+k) ticks, msb first
`timescale 1ns/100ps
`include "standby_defs.svh"
module stab_counter
  import standby_pkg::*;
#(
  parameter int BITS   = `STAB_BITS,
  parameter int CNT_W  = 16,
  parameter int BASE   = `STAB_BASE_EXP
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Control
  input  wire logic              clear,
  input  wire logic              start,
  input  wire logic [2:0]        stabTimeSelect,
  // Status
  output logic      [BITS-1:0]   stabCounterStatus,
  output logic                   done
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             running;
    logic [BITS-1:0]  status;
    logic             done;
  } stab_state_t;
  stab_state_t st, next_st;

  function automatic logic [CNT_W-1:0] limitOf(input logic [2:0] sel);
    limitOf = CNT_W'(1) << (BASE + int'(sel));
  endfunction

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (clear) begin
      next_st.status  = '0;
      // A wake pending at STOP entry starts the wait in the same cycle
      next_st.running = start;
      next_st.count   = '0;
    end else if (start) begin
      next_st.running = 1'b1;
      next_st.count   = '0;
    end else if (st.running) begin
      next_st.count = st.count + CNT_W'(1);
      // Only thresholds inside the selected interval are recorded
      for (int k = 0; k < BITS; k++) begin
        if (next_st.count >= limitOf(3'(k)) && 3'(k) <= stabTimeSelect) begin
          next_st.status[BITS-1-k] = 1'b1;
        end
      end
      if (next_st.count >= limitOf(stabTimeSelect)) begin
        next_st.running = 1'b0;
        next_st.done    = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{count: '0, running: 1'b0, status: `STAB_STATUS_RST, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign stabCounterStatus = st.status;
  assign done              = st.done;
endmodule

// [core/standby_mode_controller.sv]
// Purpose: STOP/HALT standby sequencing and oscillator control
// Assumes: Command pulses from the CPU core on mclk; intOscTick is a pin
// Notes:   Wake is level of any unmasked pending interrupt
// Behaviour
// - Oscillator stop bit obeyed only if option allows
// - STOP refused when running from subsystem clock
// - HALT allowed from every clock source
// - STOP on internal clock stops high-speed oscillator only
// - Running internal oscillator keeps running through STOP
// - Hold CPU 17 internal periods after release when on internal clock
// - Status bits set msb first, stay set
// - Counter counts only within selected stabilization time
// - Pending unmasked interrupt releases HALT at once, STOP through oscillator start and stabilization wait
// - Stabilization wait excludes oscillator start interval
`timescale 1ns/100ps
`include "standby_defs.svh"
module standby_mode_controller
  import standby_pkg::*;
#(
  parameter int OSC_START = `OSC_START_CYCLES,
  parameter int HOLD_N    = `INT_HOLD_PERIODS
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // CPU side
  input  wire cpu_cmd_t     cpuCmd,
  input  wire cpu_clk_src_t cpuClkSrc,
  // Configuration
  input  wire logic         intOscStopCtrl,
  input  wire logic         intOscStoppableOpt,
  input  wire logic [2:0]   stabTimeSelect,
  // Internal oscillator pin
  input  wire logic         intOscTick,
  // Status
  output standby_out_t      standbyOut,
  output logic [`STAB_BITS-1:0] stabCounterStatus
);
  typedef struct packed {
    standby_mode_t mode;
    logic [7:0]    cnt;
    logic [2:0]    tickSync;
    logic          tickLevel;
    logic          intOscRun;
    logic          onIntOsc;
    logic          keepIntOsc;
    standby_out_t  out;
  } ctrl_state_t;
  ctrl_state_t st, next_st;

  // Both oscillators run out of reset; nothing is held
  localparam ctrl_state_t ST_RESET = '{
    mode:       MODE_RUN,
    cnt:        8'h00,
    tickSync:   3'h0,
    tickLevel:  1'b0,
    intOscRun:  1'b1,
    onIntOsc:   1'b0,
    keepIntOsc: 1'b0,
    out:        '{
      highSpeedOscEn: 1'b1,
      intOscEn:       1'b1,
      cpuHold:        1'b0,
      inHalt:         1'b0,
      inStop:         1'b0,
      stopRefused:    1'b0
    }
  };

  // CPU stays held from oscillator start until the release hold ends
  function automatic logic holdsCpu(input standby_mode_t m);
    holdsCpu = (m == MODE_OSC_START) || (m == MODE_STAB_WAIT) || (m == MODE_INT_HOLD);
  endfunction

  function automatic logic isIntOsc(input cpu_clk_src_t src);
    isIntOsc = (src == CLK_INT_OSC);
  endfunction

  logic stabClear;
  logic stabStart;
  logic stabDone;
  logic [`STAB_BITS-1:0] stabStatus;

  stab_counter #(
    .BITS  (`STAB_BITS),
    .CNT_W (16),
    .BASE  (`STAB_BASE_EXP)
  ) u_stab (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .clear             (stabClear),
    .start             (stabStart),
    .stabTimeSelect    (stabTimeSelect),
    .stabCounterStatus (stabStatus),
    .done              (stabDone)
  );

  always_comb begin
    logic tickEdge;
    logic canStop;
    tickEdge = 1'b0;
    canStop  = 1'b0;
    next_st  = st;
    stabClear = 1'b0;
    stabStart = 1'b0;
    next_st.out.stopRefused = 1'b0;
    next_st.tickSync = {st.tickSync[1:0], intOscTick};
    // Change counts once second and third stages agree
    if (st.tickSync[2] == st.tickSync[1]) begin
      next_st.tickLevel = st.tickSync[1];
      tickEdge = st.tickSync[1] && !st.tickLevel;
    end
    // Option gate on the software stop bit
    if (intOscStoppableOpt) begin
      next_st.intOscRun = !intOscStopCtrl;
    end else begin
      next_st.intOscRun = 1'b1;
    end
    canStop = cpuClkSrc != CLK_SUBSYSTEM;
    case (st.mode)
      MODE_RUN: begin
        if (cpuCmd.stopReq) begin
          if (!canStop) begin
            next_st.out.stopRefused = 1'b1;
          end else if (cpuCmd.wakeReq) begin
            next_st.mode = MODE_STAB_WAIT;
            next_st.onIntOsc = isIntOsc(cpuClkSrc);
            next_st.out.inHalt = 1'b1;
            stabClear = 1'b1;
            stabStart = 1'b1;
          end else begin
            next_st.mode = MODE_STOP;
            next_st.onIntOsc = isIntOsc(cpuClkSrc);
            // Latched so a late change of the stop bit cannot halt it
            next_st.keepIntOsc = st.out.intOscEn;
            next_st.out.inStop = 1'b1;
            next_st.out.highSpeedOscEn = 1'b0;
            stabClear = 1'b1;
          end
        end else if (cpuCmd.haltReq) begin
          next_st.mode = MODE_HALT;
          next_st.out.inHalt = 1'b1;
        end
      end
      MODE_HALT: begin
        if (cpuCmd.wakeReq) begin
          next_st.mode = MODE_RUN;
          next_st.out.inHalt = 1'b0;
        end
      end
      MODE_STOP: begin
        if (cpuCmd.wakeReq) begin
          next_st.mode = MODE_OSC_START;
          next_st.cnt  = '0;
          next_st.keepIntOsc = 1'b0;
          next_st.out.inStop = 1'b0;
          next_st.out.inHalt = 1'b1;
          next_st.out.highSpeedOscEn = 1'b1;
        end
      end
      MODE_OSC_START: begin
        // Start-up interval is not counted as stabilization time
        if (st.cnt >= 8'(OSC_START - 1)) begin
          next_st.mode = MODE_STAB_WAIT;
          stabStart = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end
      MODE_STAB_WAIT: begin
        // Halt flag drops as the wait ends
        if (stabDone) begin
          next_st.out.inHalt = 1'b0;
          next_st.cnt = '0;
          if (st.onIntOsc) begin
            next_st.mode = MODE_INT_HOLD;
          end else begin
            next_st.mode = MODE_RUN;
            next_st.out.cpuHold = 1'b0;
          end
        end
      end
      MODE_INT_HOLD: begin
        // Counted in internal oscillator periods, not mclk cycles
        if (tickEdge) begin
          if (st.cnt >= 8'(HOLD_N - 1)) begin
            next_st.mode = MODE_RUN;
            next_st.onIntOsc = 1'b0;
            next_st.out.cpuHold = 1'b0;
          end else begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
      end
      default: begin
        next_st.mode = MODE_RUN;
      end
    endcase
    if (holdsCpu(next_st.mode)) begin
      next_st.out.cpuHold = 1'b1;
    end
    // A running internal oscillator is never stopped by STOP
    next_st.out.intOscEn = next_st.intOscRun || st.onIntOsc || st.keepIntOsc;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= ST_RESET;
      stabCounterStatus <= `STAB_STATUS_RST;
    end else begin
      st <= next_st;
      // Status trails the counter by one cycle
      stabCounterStatus <= stabStatus;
    end
  end

  assign standbyOut = st.out;
endmodule

// [bench/standby_mode_controller_asserts.sv]
// Purpose: Port checks of the standby controller
// Assumes: One mclk domain
// Notes:   Wait lengths are timed by the bench
`timescale 1ns/100ps
`include "standby_defs.svh"
module standby_mode_controller_asserts
  import standby_pkg::*;
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  reset_n,
  // Watched ports
  input wire cpu_cmd_t              cpuCmd,
  input wire cpu_clk_src_t          cpuClkSrc,
  input wire logic                  intOscStoppableOpt,
  input wire standby_out_t          standbyOut,
  input wire logic [`STAB_BITS-1:0] stabCounterStatus
);
  wire standby_out_t o = standbyOut;
  wire logic [4:0]   s = stabCounterStatus;
  // Pending wake excluded: it bends STOP into HALT
  wire logic         run = !o.inHalt && !o.inStop && !o.cpuHold && !cpuCmd.wakeReq;
  wire logic         stopGo = run && cpuCmd.stopReq;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  a_stop_refused: assert property (stopGo && cpuClkSrc == CLK_SUBSYSTEM
    |=> o.stopRefused && !o.inStop) else $error("stop taken");
  a_halt_taken: assert property (run && cpuCmd.haltReq && !cpuCmd.stopReq
    |=> o.inHalt) else $error("halt lost");
  a_stop_int_osc: assert property (stopGo && cpuClkSrc == CLK_INT_OSC
    |=> o.inStop && !o.highSpeedOscEn && o.intOscEn) else $error("bad osc in stop");
  // Status clear shows one cycle after the mode flags rise
  a_stat_sticky: assert property (!($past(o.inStop) && !$past(o.inStop, 2))
    && !($past(o.inHalt) && !$past(o.inHalt, 2))
    |-> ($past(s) & ~s) == 5'h00) else $error("status bit fell");
  a_msb_first: assert property (s inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f})
    else $error("status order");
  a_wake_stop: assert property (o.inStop && cpuCmd.wakeReq
    |=> o.inHalt && !o.inStop && o.cpuHold) else $error("no wake");
  a_osc_start: assert property ($rose(o.cpuHold) && $past(o.inStop)
    |-> (s == 5'h00) [*8]) else $error("counted early");
  a_opt_lock: assert property (!intOscStoppableOpt && !$past(intOscStoppableOpt)
    |-> o.intOscEn) else $error("osc stopped");
  c_refuse: cover property (o.stopRefused);
  c_release: cover property ($fell(o.cpuHold));
  c_halt_wake: cover property (o.inHalt && cpuCmd.wakeReq);
endmodule
bind standby_mode_controller standby_mode_controller_asserts u_chk (
  .mclk(mclk), .reset_n(reset_n), .cpuCmd(cpuCmd), .cpuClkSrc(cpuClkSrc),
  .intOscStoppableOpt(intOscStoppableOpt), .standbyOut(standbyOut),
  .stabCounterStatus(stabCounterStatus));

// [bench/standby_mode_controller_bench.sv]
// Purpose: Directed test of the standby controller
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Tick pin slightly off five mclk, phase drifts
`timescale 1ns/100ps
module standby_mode_controller_bench
  import standby_pkg::*;
;
  logic         mclk = 1'h0;
  logic         reset_n = 1'h0;
  logic         tick = 1'h0;
  logic         stopCtrl = 1'h0;
  logic         stopOpt = 1'h0;
  logic [2:0]   sel = 3'h0;
  cpu_cmd_t     cmd = '0;
  cpu_clk_src_t src = CLK_HIGH_SPEED;
  standby_out_t out;
  logic [4:0]   stat;
  int           err_count = 0;
  int           n_checks = 0;
  int           n;
  always #10 mclk = ~mclk;
  always #50.3 tick = ~tick;
  standby_mode_controller dut (.mclk(mclk), .reset_n(reset_n), .cpuCmd(cmd), .cpuClkSrc(src),
    .intOscStopCtrl(stopCtrl), .intOscStoppableOpt(stopOpt), .stabTimeSelect(sel),
    .intOscTick(tick), .standbyOut(out), .stabCounterStatus(stat));
  task automatic chkf(input standby_out_t got, input standby_out_t exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic issue(input logic h, input logic st);
    cmd.haltReq = h;
    cmd.stopReq = st;
    step(1);
    cmd.haltReq = 1'h0;
    cmd.stopReq = 1'h0;
  endtask
  // Wake held as a level until RUN, bounded so a hang still ends
  task automatic wake(output int c);
    cmd.wakeReq = 1'h1;
    for (c = 0; c < 5000 && {out.inHalt, out.inStop, out.cpuHold} !== 3'h0; c++) begin
      step(1);
    end
    cmd.wakeReq = 1'h0;
    chkn(c < 5000, 12'h1);
  endtask
  function automatic logic [4:0] expStat(input int s);
    return (s > 4) ? 5'h1f : ~(5'h1f >> (s + 1));
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    step(20);
    reset_n = 1'h1;
    chkf(out, 6'h30);
    chkn(stat, 12'h0);
    src = CLK_SUBSYSTEM;
    issue(1'h0, 1'h1);
    chkf(out, 6'h31);
    for (int i = 0; i < 3; i++) begin
      src = cpu_clk_src_t'(i);
      issue(1'h1, 1'h0);
      chkf(out, 6'h34);
      wake(n);
    end
    src = CLK_HIGH_SPEED;
    for (int i = 0; i < 8; i += 2) begin
      sel = 3'(i);
      issue(1'h0, 1'h1);
      chkf(out, 6'h12);
      // Status output trails the mode flags by one cycle
      step(1);
      chkn(stat, 12'h0);
      wake(n);
      step(2);
      chkf(out, 6'h30);
      chkn(stat, expStat(i));
      chkn(n >= 8 + (16 << i) && n <= 16 + (16 << i), 12'h1);
    end
    src = CLK_INT_OSC;
    sel = 3'h0;
    issue(1'h0, 1'h1);
    chkf(out, 6'h12);
    wake(n);
    chkn(n >= 24 + 17 * 4 && n <= 32 + 17 * 6, 12'h1);
    chkn(stat, expStat(0));
    chkf(out, 6'h30);
    src = CLK_HIGH_SPEED;
    cmd.wakeReq = 1'h1;
    issue(1'h0, 1'h1);
    chkn({out.inHalt, out.inStop}, 12'h2);
    wake(n);
    chkn(n >= 16 && n <= 20, 12'h1);
    stopCtrl = 1'h1;
    step(2);
    chkn(out.intOscEn, 12'h1);
    stopOpt = 1'h1;
    step(2);
    chkn(out.intOscEn, 12'h0);
    stopCtrl = 1'h0;
    step(2);
    stopOpt = 1'h0;
    step(2);
    print_verdict;
  end
  // Tests need about 2000 cycles; this allows five times more
  initial begin
    #200000;
    err_count++;
    print_verdict;
  end
endmodule
